// *** training_regs_pkg.sv ***
// constants for the link-training control and status register slice
package training_regs_pkg;

  // ----------------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------------
  localparam logic [11:0] IDX_RX_EQ_CONTROL = 12'h4D0;
  localparam logic [11:0] IDX_COMMAND_STROBES = 12'h4D1;
  localparam logic [11:0] IDX_TRAINING_STATUS = 12'h4D2;
  localparam logic [11:0] IDX_COEF_CONTENT = 12'h4D4;
  localparam int ADDR_W = 16;
  localparam logic [15:0] ADDR_RX_EQ_CONTROL = {2'h0, IDX_RX_EQ_CONTROL, 2'h0};
  localparam logic [15:0] ADDR_COMMAND_STROBES =
    {2'h0, IDX_COMMAND_STROBES, 2'h0};
  localparam logic [15:0] ADDR_TRAINING_STATUS =
    {2'h0, IDX_TRAINING_STATUS, 2'h0};
  localparam logic [15:0] ADDR_COEF_CONTENT = {2'h0, IDX_COEF_CONTENT, 2'h0};

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BIT_LP_OVERRIDE = 16;
  localparam int BIT_LOCAL_OVERRIDE = 17;
  localparam int BIT_ADAPT_MODE = 22;
  localparam int CTLE_LSB = 24;
  localparam int VGA_LSB = 29;
  localparam int BIT_RESTART = 0;
  localparam int BIT_TX_COEF_NEW = 4;
  localparam int BIT_RX_COEF_NEW = 8;
  localparam int LOCAL_COEF_LSB = 16;

  // ----------------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------------
  localparam logic RST_ADAPT_MODE_SIM = 1'h1;
  localparam logic RST_ADAPT_MODE_HW = 1'h0;
  localparam logic [4:0] RST_CTLE = 5'h01;
  localparam logic [2:0] RST_VGA_SIM = 3'h4;
  localparam logic [2:0] RST_VGA_HW = 3'h7;
  localparam logic [31:0] RST_COEF = 32'h0000_0000;
  localparam logic [7:0] RST_STATUS = 8'h00;

  // ----------------------------------------------------------------------
  // coefficient update codes and bus answers
  // ----------------------------------------------------------------------
  localparam logic [1:0] COEF_HOLD = 2'h0;
  localparam logic [1:0] COEF_INC = 2'h1;
  localparam logic [1:0] COEF_DEC = 2'h2;
  localparam logic [1:0] COEF_RSVD = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** kr_link_training_ctrl_status.sv ***
// axi4-lite register slice steering the backplane link-training engine
// Operation
// - mode 0 sweeps equalizer before tx-eq; mode 1 applies manual value.
// - adaptation mode resets to 1 in simulation builds, 0 in hardware.
// - manual ctle field used only in manual mode; resets to 1.
// - manual vga used only in manual mode; resets 4 sim, 7 hardware.
// - writing 1 to restart bit restarts start-up protocol, then self-clears.
// - tx-coefficient strobe starts sending coefficient low byte to partner.
// - tx-coefficient strobe self-clears; needs partner override enable set.
// - rx-coefficient strobe loads local tx equalizer from third byte.
// - rx-coefficient strobe self-clears; needs local override enable set.
// - status bit 0 reports receiver trained.
// - status bit 1 reports training frame lock.
// - status bit 2 reports start-up protocol running.
// - status bit 3 reports training failure.
// - status bit 4 reports excessive bit errors during training.
// - status bit 5 reports frame lock lost during training.
// - status bit 6 reports frame loss during receive equalization.
// - status bit 7 reports fine-tuning found no best equalizer value.
// - partner override enable makes partner updates come from software.
// - update fields: 00 hold, 01 increment, 10 decrement, 11 reserved.
`timescale 1ns/100ps
module kr_link_training_ctrl_status #(
  parameter bit SIM_BUILD = 1'b0
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // axi4-lite write address and data
  input wire logic [15:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // axi4-lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [15:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // equalizer settings to the training engine
  output logic o_ctle_sweep_en,
  output logic o_manual_eq_en,
  output logic [4:0] o_ctle_value,
  output logic [2:0] o_vga_value,
  // command pulses, partner override level and coefficient values to the training engine
  output logic o_restart_training,
  output logic o_lp_coef_from_sw,
  output logic o_tx_coef_send,
  output logic [7:0] o_tx_coef_update,
  output logic o_local_coef_load,
  output logic [7:0] o_local_coef_value,
  // status levels from the training engine, same clock
  input wire logic i_rx_trained,
  input wire logic i_frame_lock,
  input wire logic i_startup_busy,
  input wire logic i_training_failure,
  input wire logic i_training_error,
  input wire logic i_frame_lock_error,
  input wire logic i_receive_equalization_frame_loss,
  input wire logic i_fine_tune_error
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic logic is_mapped(input logic [15:0] a);
    is_mapped = (a == training_regs_pkg::ADDR_RX_EQ_CONTROL) ||
                (a == training_regs_pkg::ADDR_COMMAND_STROBES) ||
                (a == training_regs_pkg::ADDR_TRAINING_STATUS) ||
                (a == training_regs_pkg::ADDR_COEF_CONTENT);
  endfunction

  // reserved code 11 is sent as hold in the three low update fields; bits 7:6 are passed on as written
  function automatic logic [1:0] clean_code(input logic [1:0] c);
    clean_code = (c == training_regs_pkg::COEF_RSVD) ?
                 training_regs_pkg::COEF_HOLD : c;
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    byte_merge = r;
  endfunction

  localparam logic RST_MODE = SIM_BUILD ? training_regs_pkg::RST_ADAPT_MODE_SIM
                                        : training_regs_pkg::RST_ADAPT_MODE_HW;
  localparam logic [2:0] RST_VGA = SIM_BUILD ? training_regs_pkg::RST_VGA_SIM
                                             : training_regs_pkg::RST_VGA_HW;
  localparam logic [31:0] RST_CTRL = {RST_VGA, training_regs_pkg::RST_CTLE,
                                      1'h0, RST_MODE, 22'h0};

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] coef, next_coef;
  logic [7:0] status, next_status;
  logic aw_have, next_aw_have;
  logic w_have, next_w_have;
  logic [15:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic next_restart, next_tx_send, next_local_load;
  logic [7:0] next_tx_update, next_local_value;
  logic next_sweep, next_manual, next_lp_sw;
  logic [4:0] next_ctle;
  logic [2:0] next_vga;
  logic do_write, take_aw, take_w, take_ar;

  // ----------------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------------
  always_comb begin
    take_aw = i_awvalid && o_awready;
    take_w = i_wvalid && o_wready;
    take_ar = i_arvalid && o_arready;
    next_aw_have = aw_have || take_aw;
    next_w_have = w_have || take_w;
    next_aw_addr = take_aw ? i_awaddr : aw_addr;
    next_w_data = take_w ? i_wdata : w_data;
    next_w_strb = take_w ? i_wstrb : w_strb;
    next_ctrl = ctrl;
    next_coef = coef;
    next_bvalid = o_bvalid && !i_bready;
    next_bresp = o_bresp;
    next_restart = 1'b0;
    next_tx_send = 1'b0;
    next_local_load = 1'b0;
    next_tx_update = o_tx_coef_update;
    next_local_value = o_local_coef_value;
    // write commits once both address and data are held
    do_write = aw_have && w_have && !o_bvalid;
    if (do_write) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_mapped(aw_addr) ? training_regs_pkg::RESP_OKAY
                                      : training_regs_pkg::RESP_SLVERR;
      unique case (aw_addr)
        training_regs_pkg::ADDR_RX_EQ_CONTROL: begin
          next_ctrl = byte_merge(ctrl, w_data, w_strb);
        end
        training_regs_pkg::ADDR_COEF_CONTENT: begin
          next_coef = byte_merge(coef, w_data, w_strb);
        end
        training_regs_pkg::ADDR_COMMAND_STROBES: begin
          // strobes live one cycle only, so a 0 write changes nothing
          next_restart = w_strb[0] &&
                         w_data[training_regs_pkg::BIT_RESTART];
          next_tx_send = w_strb[0] && ctrl[training_regs_pkg::BIT_LP_OVERRIDE]
                         && w_data[training_regs_pkg::BIT_TX_COEF_NEW];
          next_local_load = w_strb[1] &&
                            ctrl[training_regs_pkg::BIT_LOCAL_OVERRIDE] &&
                            w_data[training_regs_pkg::BIT_RX_COEF_NEW];
        end
        default: begin
          // status word and unmapped words: nothing stored
          next_ctrl = ctrl;
        end
      endcase
      if (next_tx_send) begin
        next_tx_update = {coef[7:6], clean_code(coef[5:4]),
                          clean_code(coef[3:2]), clean_code(coef[1:0])};
      end
      if (next_local_load) begin
        next_local_value =
          coef[training_regs_pkg::LOCAL_COEF_LSB +: 8];
      end
    end
    next_awready = !next_aw_have && !next_bvalid;
    next_wready = !next_w_have && !next_bvalid;
    // settings only follow the manual fields in manual mode
    next_manual = next_ctrl[training_regs_pkg::BIT_ADAPT_MODE];
    next_sweep = !next_ctrl[training_regs_pkg::BIT_ADAPT_MODE];
    next_ctle = next_manual ?
                next_ctrl[training_regs_pkg::CTLE_LSB +: 5] : 5'h00;
    next_vga = next_manual ?
               next_ctrl[training_regs_pkg::VGA_LSB +: 3] : 3'h0;
    next_lp_sw = next_ctrl[training_regs_pkg::BIT_LP_OVERRIDE];
    // status mirrors the engine each cycle
    next_status = {i_fine_tune_error,
                   i_receive_equalization_frame_loss,
                   i_frame_lock_error,
                   i_training_error,
                   i_training_failure,
                   i_startup_busy,
                   i_frame_lock,
                   i_rx_trained};
    // read channel: one outstanding read, answered a cycle after address
    next_rvalid = o_rvalid && !i_rready;
    next_rdata = o_rdata;
    next_rresp = o_rresp;
    if (take_ar) begin
      next_rvalid = 1'b1;
      next_rresp = is_mapped(i_araddr) ? training_regs_pkg::RESP_OKAY
                                       : training_regs_pkg::RESP_SLVERR;
      unique case (i_araddr)
        training_regs_pkg::ADDR_RX_EQ_CONTROL: next_rdata = ctrl;
        training_regs_pkg::ADDR_COEF_CONTENT: next_rdata = coef;
        training_regs_pkg::ADDR_COMMAND_STROBES: begin
          next_rdata = {23'h0, o_local_coef_load, 3'h0, o_tx_coef_send,
                        3'h0, o_restart_training};
        end
        training_regs_pkg::ADDR_TRAINING_STATUS: begin
          next_rdata = {24'h0, status};
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    next_arready = !next_rvalid;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ctrl <= RST_CTRL;
      coef <= training_regs_pkg::RST_COEF;
      status <= training_regs_pkg::RST_STATUS;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 16'h0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= training_regs_pkg::RESP_OKAY;
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= training_regs_pkg::RESP_OKAY;
      o_restart_training <= 1'b0;
      o_tx_coef_send <= 1'b0;
      o_local_coef_load <= 1'b0;
      o_tx_coef_update <= 8'h00;
      o_local_coef_value <= 8'h00;
      o_manual_eq_en <= RST_MODE;
      o_ctle_sweep_en <= !RST_MODE;
      o_ctle_value <= RST_MODE ? training_regs_pkg::RST_CTLE : 5'h00;
      o_vga_value <= RST_MODE ? RST_VGA : 3'h0;
      o_lp_coef_from_sw <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      coef <= next_coef;
      status <= next_status;
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      o_awready <= next_awready;
      o_wready <= next_wready;
      o_bvalid <= next_bvalid;
      o_bresp <= next_bresp;
      o_arready <= next_arready;
      o_rvalid <= next_rvalid;
      o_rdata <= next_rdata;
      o_rresp <= next_rresp;
      o_restart_training <= next_restart;
      o_tx_coef_send <= next_tx_send;
      o_local_coef_load <= next_local_load;
      o_tx_coef_update <= next_tx_update;
      o_local_coef_value <= next_local_value;
      o_manual_eq_en <= next_manual;
      o_ctle_sweep_en <= next_sweep;
      o_ctle_value <= next_ctle;
      o_vga_value <= next_vga;
      o_lp_coef_from_sw <= next_lp_sw;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  logic past_valid;
  always_ff @(posedge i_clk_sys) begin
    past_valid <= i_rst_n;
  end

  sequence strobe_write_s(int b);
    do_write && aw_addr == training_regs_pkg::ADDR_COMMAND_STROBES &&
    w_strb[b/8] && w_data[b];
  endsequence

  mode_exclusive_a: assert property (
    o_manual_eq_en != o_ctle_sweep_en)
    else $error("sweep and manual both or neither");

  reset_mode_a: assert property (
    !past_valid |-> o_manual_eq_en == SIM_BUILD)
    else $error("adaptation mode wrong after reset");

  ctle_gated_a: assert property (
    !o_manual_eq_en |-> o_ctle_value == 5'h00 && o_vga_value == 3'h0)
    else $error("manual values leak in adaptive mode");

  vga_follow_a: assert property (
    o_manual_eq_en |-> o_vga_value == ctrl[training_regs_pkg::VGA_LSB +: 3]
    && o_ctle_value == ctrl[training_regs_pkg::CTLE_LSB +: 5])
    else $error("vga not applied in manual mode");

  restart_pulse_a: assert property (
    strobe_write_s(training_regs_pkg::BIT_RESTART) |=>
    o_restart_training ##1 !o_restart_training)
    else $error("restart not a single pulse");

  tx_send_a: assert property (
    strobe_write_s(training_regs_pkg::BIT_TX_COEF_NEW) ##0
    ctrl[training_regs_pkg::BIT_LP_OVERRIDE] |=>
    o_tx_coef_send && o_tx_coef_update[7:6] == $past(coef[7:6]))
    else $error("tx coefficient strobe lost");

  tx_needs_override_a: assert property (
    o_tx_coef_send |-> $past(ctrl[training_regs_pkg::BIT_LP_OVERRIDE]))
    else $error("tx strobe without override");

  local_load_a: assert property (
    strobe_write_s(training_regs_pkg::BIT_RX_COEF_NEW) ##0
    ctrl[training_regs_pkg::BIT_LOCAL_OVERRIDE] |=>
    o_local_coef_load && o_local_coef_value == $past(coef[23:16]))
    else $error("local coefficient load lost");

  local_needs_override_a: assert property (
    o_local_coef_load |-> $past(ctrl[training_regs_pkg::BIT_LOCAL_OVERRIDE]))
    else $error("local load without override");

  status_track_a: assert property (
    ##1 status == $past({i_fine_tune_error, i_receive_equalization_frame_loss,
                         i_frame_lock_error, i_training_error,
                         i_training_failure, i_startup_busy, i_frame_lock,
                         i_rx_trained}))
    else $error("status does not track engine");

  no_reserved_code_a: assert property (
    o_tx_coef_send |-> o_tx_coef_update[1:0] != training_regs_pkg::COEF_RSVD
    && o_tx_coef_update[3:2] != training_regs_pkg::COEF_RSVD
    && o_tx_coef_update[5:4] != training_regs_pkg::COEF_RSVD)
    else $error("reserved update code sent");

  lp_source_a: assert property (
    ##1 o_lp_coef_from_sw == $past(next_ctrl[16]))
    else $error("partner override not reflected");

  write_answer_a: assert property (
    do_write |=> o_bvalid)
    else $error("write not answered");

endmodule

// *** training_engine_model.sv ***
// behavioural stand-in for the training engine beside the register slice
`timescale 1ns/100ps
module training_engine_model (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // restart pulse from the register slice
  input wire logic i_restart,
  // status levels chosen by the bench
  input wire logic [7:0] i_level,
  // status levels to the register slice
  output logic [7:0] o_status
);
  logic [2:0] busy_cnt;
  logic [2:0] next_busy_cnt;
  // ----------------------------------------------------------------------
  // start-up protocol after a restart
  // ----------------------------------------------------------------------
  // long enough that a read right after the restart write sees it
  always_comb begin
    next_busy_cnt = busy_cnt;
    if (i_restart) begin
      next_busy_cnt = 3'h7;
    end else if (busy_cnt != 3'h0) begin
      next_busy_cnt = busy_cnt - 3'h1;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      busy_cnt <= 3'h0;
    end else begin
      busy_cnt <= next_busy_cnt;
    end
  end
  // busy start-up drops trained and raises the start-up flag
  assign o_status = (busy_cnt != 3'h0) ?
    ((i_level | 8'h04) & 8'hFE) : i_level;
endmodule

// *** kr_link_training_ctrl_status_test.sv ***
// self-checking bench for the link-training register slice
`timescale 1ns/100ps
module kr_link_training_ctrl_status_test;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0;
  logic [15:0] i_awaddr = 16'h0000, i_araddr = 16'h0000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [3:0] i_wstrb = 4'hF;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic o_ctle_sweep_en, o_manual_eq_en, o_restart_training;
  logic [4:0] o_ctle_value;
  logic [2:0] o_vga_value;
  logic o_lp_coef_from_sw, o_tx_coef_send, o_local_coef_load;
  logic [7:0] o_tx_coef_update, o_local_coef_value, status, last_upd;
  logic [7:0] level = 8'h00;
  int mismatches = 0, n_checks = 0, cyc = 0, n_rst = 0, n_tx = 0, n_ld = 0;

  always #5 i_clk_sys = ~i_clk_sys;

  kr_link_training_ctrl_status uut (
    .i_clk_sys, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
    .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
    .o_rvalid, .i_rready, .o_ctle_sweep_en, .o_manual_eq_en,
    .o_ctle_value, .o_vga_value, .o_restart_training,
    .o_lp_coef_from_sw, .o_tx_coef_send, .o_tx_coef_update,
    .o_local_coef_load, .o_local_coef_value,
    .i_rx_trained(status[0]), .i_frame_lock(status[1]),
    .i_startup_busy(status[2]), .i_training_failure(status[3]),
    .i_training_error(status[4]), .i_frame_lock_error(status[5]),
    .i_receive_equalization_frame_loss(status[6]), .i_fine_tune_error(status[7])
  );

  training_engine_model partner (
    .i_clk_sys, .i_rst_n, .i_restart(o_restart_training),
    .i_level(level), .o_status(status)
  );

  // ----------------------------------------------------------------------
  // pulse monitor and hang guard
  // ----------------------------------------------------------------------
  // counted at the falling edge, where the pulses are settled
  always @(negedge i_clk_sys) begin
    if (o_restart_training === 1'b1) n_rst++;
    if (o_local_coef_load === 1'b1) n_ld++;
    if (o_tx_coef_send === 1'b1) begin
      n_tx++;
      last_upd = o_tx_coef_update;
    end
  end

  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // handshakes judged at the falling edge, acted on at the next rising one
  task wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge i_clk_sys);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge i_clk_sys);
      aw = i_awvalid && o_awready;
      w = i_wvalid && o_wready;
      b = o_bvalid;
      r = o_bresp;
      @(posedge i_clk_sys);
      if (aw) i_awvalid <= 1'b0;
      if (w) i_wvalid <= 1'b0;
    end
    i_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(r));
    @(negedge i_clk_sys);
  endtask

  task rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge i_clk_sys);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge i_clk_sys);
      ar = i_arvalid && o_arready;
      v = o_rvalid;
      d = o_rdata;
      r = o_rresp;
      @(posedge i_clk_sys);
      if (ar) i_arvalid <= 1'b0;
    end
    i_rready <= 1'b0;
    chk("rresp", 32'(er), 32'(r));
    chk("rdata", ed, d);
    @(negedge i_clk_sys);
  endtask

  task chk_eq(input logic [9:0] exp);
    chk("eq outputs", 32'(exp), 32'({o_ctle_sweep_en, o_manual_eq_en,
      o_ctle_value, o_vga_value}));
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task t_reset;
    rd(training_regs_pkg::ADDR_RX_EQ_CONTROL, 32'hE100_0000,
      training_regs_pkg::RESP_OKAY);
    rd(training_regs_pkg::ADDR_COMMAND_STROBES, 32'h0000_0000,
      training_regs_pkg::RESP_OKAY);
    chk_eq(10'h200);
    $display("test reset done");
  endtask

  task t_eq;
    wr(training_regs_pkg::ADDR_RX_EQ_CONTROL, 32'h7540_0000,
      training_regs_pkg::RESP_OKAY);
    chk_eq(10'h1AB);
    rd(training_regs_pkg::ADDR_RX_EQ_CONTROL, 32'h7540_0000,
      training_regs_pkg::RESP_OKAY);
    wr(training_regs_pkg::ADDR_RX_EQ_CONTROL, 32'h7500_0000,
      training_regs_pkg::RESP_OKAY);
    chk_eq(10'h200);
    $display("test equalizer mode done");
  endtask

  task t_restart;
    level <= 8'h01;
    wr(training_regs_pkg::ADDR_COMMAND_STROBES, 32'h0000_0001,
      training_regs_pkg::RESP_OKAY);
    chk("restart pulses", 32'h1, 32'(n_rst));
    rd(training_regs_pkg::ADDR_COMMAND_STROBES, 32'h0000_0000,
      training_regs_pkg::RESP_OKAY);
    rd(training_regs_pkg::ADDR_TRAINING_STATUS, 32'h0000_0004,
      training_regs_pkg::RESP_OKAY);
    wr(training_regs_pkg::ADDR_COMMAND_STROBES, 32'h0000_0000,
      training_regs_pkg::RESP_OKAY);
    chk("restart pulses", 32'h1, 32'(n_rst));
    $display("test restart done");
  endtask

  task t_coef;
    wr(training_regs_pkg::ADDR_COEF_CONTENT, 32'h00AB_00E7,
      training_regs_pkg::RESP_OKAY);
    wr(training_regs_pkg::ADDR_COMMAND_STROBES, 32'h0000_0110,
      training_regs_pkg::RESP_OKAY);
    chk("strobes while override off", 32'h0, 32'(n_tx + n_ld));
    wr(training_regs_pkg::ADDR_RX_EQ_CONTROL, 32'h0003_0000,
      training_regs_pkg::RESP_OKAY);
    chk("lp from sw", 32'h1, 32'(o_lp_coef_from_sw));
    wr(training_regs_pkg::ADDR_COMMAND_STROBES, 32'h0000_0010,
      training_regs_pkg::RESP_OKAY);
    chk("tx sends", 32'h1, 32'(n_tx));
    chk("tx update", 32'hE4, 32'(last_upd));
    wr(training_regs_pkg::ADDR_COMMAND_STROBES, 32'h0000_0100,
      training_regs_pkg::RESP_OKAY);
    chk("local loads", 32'h1, 32'(n_ld));
    chk("local value", 32'hAB, 32'(o_local_coef_value));
    rd(training_regs_pkg::ADDR_COMMAND_STROBES, 32'h0000_0000,
      training_regs_pkg::RESP_OKAY);
    $display("test coefficient strobes done");
  endtask

  task t_status;
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk_sys);
      level <= 8'h01 << i;
      repeat (3) @(posedge i_clk_sys);
      rd(training_regs_pkg::ADDR_TRAINING_STATUS, 32'h1 << i,
        training_regs_pkg::RESP_OKAY);
    end
    wr(training_regs_pkg::ADDR_TRAINING_STATUS, 32'h0000_00FF,
      training_regs_pkg::RESP_OKAY);
    rd(training_regs_pkg::ADDR_TRAINING_STATUS, 32'h0000_0080,
      training_regs_pkg::RESP_OKAY);
    wr(16'h1360, 32'hFFFF_FFFF, training_regs_pkg::RESP_SLVERR);
    rd(16'h1360, 32'h0000_0000, training_regs_pkg::RESP_SLVERR);
    $display("test status done");
  endtask

  // ----------------------------------------------------------------------
  // verdict
  // ----------------------------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    t_reset();
    t_eq();
    t_restart();
    t_coef();
    t_status();
    end_sim();
  end
endmodule
